// ---- include/asp_pkg.sv ----
// package for the asynchronous sram host controller
package asp_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int NUM_LANES = 2;
  localparam int WORD_COUNT = 262144;
  localparam int CLK_PERIOD_NS = 20;
  // write pulse, read access and bus turnaround times, worst speed grade
  localparam int WRITE_PULSE_NS = 14;
  localparam int READ_ACCESS_NS = 25;
  localparam int TURN_NS = 8;
  localparam logic [3:0] WRITE_CYC =
    4'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] READ_CYC =
    4'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
  localparam logic [3:0] TURN_CYC =
    4'((TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ASP_IDLE = 2'b00,
    ASP_WRITE = 2'b01,
    ASP_READ = 2'b10,
    ASP_TURN = 2'b11
  } asp_state_type;

  typedef struct packed {
    logic chip_sel_n;
    logic write_en_n;
    logic out_en_n;
    logic low_byte_sel_n;
    logic high_byte_sel_n;
  } asp_strobe_type;

  typedef struct packed {
    asp_state_type state;
    logic [3:0] cnt;
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic data_oe;
    asp_strobe_type strobe;
  } asp_regs_type;
endpackage

// ---- core/asp_host.sv ----
// host controller driving an asynchronous 256k x 16 sram with byte lanes
`timescale 1ns/100ps
`default_nettype none
module asp_host import asp_pkg::*; (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic req_valid_i, // access request
  output logic req_ready_o, // request accepted when high with valid
  input wire logic req_write_i, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] req_addr_i, // word address
  input wire logic [DATA_W-1:0] req_wdata_i, // write data
  input wire logic [NUM_LANES-1:0] req_lane_i, // lane enables, bit0 low byte
  output logic [DATA_W-1:0] rsp_rdata_o, // read data
  output logic rsp_valid_o, // one cycle pulse with read data
  output logic [ADDR_W-1:0] word_address_o, // memory address pins
  output logic chip_sel_n_o, // chip select, active low
  output logic write_en_n_o, // write enable, active low
  output logic out_en_n_o, // output enable, active low
  output logic low_byte_sel_n_o, // low lane select, active low
  output logic high_byte_sel_n_o, // high lane select, active low
  output logic test_pin_tie_o, // test pin, tied low
  input wire logic [DATA_W-1:0] data_lanes_i, // data bus input
  output logic [DATA_W-1:0] data_lanes_o, // data bus output
  output logic data_lanes_oe_o // data bus enable, high while driving
);
  asp_regs_type r_q;
  asp_regs_type r_d;
  asp_strobe_type idle_strobe;
  logic [NUM_LANES-1:0] lane_sel_n;

  // every strobe high leaves the memory in standby between accesses
  assign idle_strobe = '{
    chip_sel_n: 1'b1,
    write_en_n: 1'b1,
    out_en_n: 1'b1,
    low_byte_sel_n: 1'b1,
    high_byte_sel_n: 1'b1
  };

  // one lane select per byte lane
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++) begin : g_lane
      assign lane_sel_n[g] = ~req_lane_i[g];
    end
  endgenerate

  always_comb begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    case (r_q.state)
      ASP_IDLE: begin
        r_d.strobe = idle_strobe;
        r_d.data_oe = 1'b0;
        if (req_valid_i) begin
          r_d.word_address = req_addr_i;
          r_d.strobe.chip_sel_n = 1'b0;
          r_d.strobe.low_byte_sel_n = lane_sel_n[0];
          r_d.strobe.high_byte_sel_n = lane_sel_n[1];
          r_d.cnt = CNT_RESET;
          if (req_write_i) begin
            // output enable stays high so the memory never fights our drive
            r_d.strobe.write_en_n = 1'b0;
            r_d.wdata = req_wdata_i;
            r_d.data_oe = 1'b1;
            r_d.state = ASP_WRITE;
          end else begin
            r_d.strobe.out_en_n = 1'b0;
            r_d.state = ASP_READ;
          end
        end
      end
      ASP_WRITE: begin
        r_d.cnt = r_q.cnt + 4'h1;
        if (r_q.cnt + 4'h1 >= WRITE_CYC) begin
          // all strobes rise together, data held one more cycle for hold time
          r_d.strobe = idle_strobe;
          r_d.state = ASP_TURN;
          r_d.cnt = CNT_RESET;
        end
      end
      ASP_READ: begin
        r_d.cnt = r_q.cnt + 4'h1;
        if (r_q.cnt + 4'h1 >= READ_CYC) begin
          r_d.rdata = data_lanes_i;
          r_d.rvalid = 1'b1;
          r_d.strobe = idle_strobe;
          r_d.state = ASP_TURN;
          r_d.cnt = CNT_RESET;
        end
      end
      ASP_TURN: begin
        // gap lets memory outputs reach high impedance before the next drive
        r_d.data_oe = 1'b0;
        r_d.cnt = r_q.cnt + 4'h1;
        if (r_q.cnt + 4'h1 >= TURN_CYC) begin
          r_d.state = ASP_IDLE;
        end
      end
      default: begin
        r_d.state = ASP_IDLE;
        r_d.strobe = idle_strobe;
        r_d.data_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      r_q.state <= ASP_IDLE;
      r_q.cnt <= CNT_RESET;
      r_q.word_address <= '0;
      r_q.wdata <= DATA_RESET;
      r_q.rdata <= DATA_RESET;
      r_q.rvalid <= 1'b0;
      r_q.data_oe <= 1'b0;
      r_q.strobe <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    end else begin
      r_q <= r_d;
    end
  end

  assign req_ready_o = (r_q.state == ASP_IDLE);
  assign rsp_rdata_o = r_q.rdata;
  assign rsp_valid_o = r_q.rvalid;
  assign word_address_o = r_q.word_address;
  assign chip_sel_n_o = r_q.strobe.chip_sel_n;
  assign write_en_n_o = r_q.strobe.write_en_n;
  assign out_en_n_o = r_q.strobe.out_en_n;
  assign low_byte_sel_n_o = r_q.strobe.low_byte_sel_n;
  assign high_byte_sel_n_o = r_q.strobe.high_byte_sel_n;
  assign test_pin_tie_o = 1'b0;
  assign data_lanes_o = r_q.wdata;
  assign data_lanes_oe_o = r_q.data_oe;

  // strobe discipline: write and read never overlap, standby stays quiet
  chk_write_needs_cs: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !write_en_n_o |-> !chip_sel_n_o && data_lanes_oe_o && out_en_n_o)
    else $error("write strobe without select or drive");
  chk_read_strobes: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !out_en_n_o |-> write_en_n_o && !chip_sel_n_o && !data_lanes_oe_o)
    else $error("read strobes inconsistent");
  chk_idle_standby: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_ready_o |-> chip_sel_n_o && write_en_n_o && out_en_n_o)
    else $error("strobes active while idle");
  chk_standby_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    chip_sel_n_o |-> write_en_n_o && out_en_n_o)
    else $error("write or output enable active while deselected");
  chk_idle_no_drive: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_ready_o |-> !data_lanes_oe_o)
    else $error("data bus driven while idle");
  chk_test_pin_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !test_pin_tie_o)
    else $error("test pin not tied low");

  // write window: one cycle of strobes, data held one cycle beyond it
  chk_write_pulse_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(write_en_n_o) |-> !write_en_n_o [*1] ##1 write_en_n_o)
    else $error("write pulse length wrong");
  chk_write_end_all: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(write_en_n_o) |-> chip_sel_n_o && low_byte_sel_n_o && high_byte_sel_n_o)
    else $error("strobes did not end the write together");
  chk_write_end_ready: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(write_en_n_o) |-> ##1 req_ready_o)
    else $error("controller not ready after write");
  chk_data_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(write_en_n_o) |-> data_lanes_oe_o && $stable(data_lanes_o))
    else $error("write data not held past strobe end");
  chk_wdata_held: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    data_lanes_oe_o && $past(data_lanes_oe_o) |-> $stable(data_lanes_o))
    else $error("write data changed while driven");

  // read: output enable held three cycles, data taken on the last of them
  chk_read_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(out_en_n_o) |-> !out_en_n_o [*3] ##1 out_en_n_o)
    else $error("read strobe length wrong");
  chk_read_latency: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(out_en_n_o) |-> ##3 rsp_valid_o)
    else $error("read data not returned in time");
  chk_read_sampled: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rsp_valid_o |-> !$past(out_en_n_o) && !$past(chip_sel_n_o))
    else $error("read data taken outside the read window");
  chk_read_end: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(out_en_n_o) |-> chip_sel_n_o && rsp_valid_o)
    else $error("read did not end with data returned");
  chk_valid_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("read valid longer than one cycle");

  // request capture, then address and lanes held for the whole access
  chk_lane_select: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_valid_i && req_ready_o |=> low_byte_sel_n_o == !$past(req_lane_i[0]) &&
    high_byte_sel_n_o == !$past(req_lane_i[1]))
    else $error("lane selects do not follow request");
  chk_lanes_held: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !chip_sel_n_o && !$past(chip_sel_n_o) |->
    $stable(low_byte_sel_n_o) && $stable(high_byte_sel_n_o))
    else $error("lane selects moved during an access");
  chk_addr_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_valid_i && req_ready_o |=> word_address_o == $past(req_addr_i))
    else $error("address not captured");
  chk_addr_held: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !chip_sel_n_o && !$past(chip_sel_n_o) |-> $stable(word_address_o))
    else $error("address moved during an access");

  cov_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(write_en_n_o));
  cov_read: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) rsp_valid_o);
  cov_low_byte_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !write_en_n_o && !low_byte_sel_n_o && high_byte_sel_n_o);
  cov_word_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !write_en_n_o && !low_byte_sel_n_o && !high_byte_sel_n_o);
  cov_high_byte_read: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !out_en_n_o && low_byte_sel_n_o && !high_byte_sel_n_o);
endmodule
`default_nettype wire

// ---- testbench/asp_sram_model.sv ----
// behavioural 256k x 16 memory with byte lanes, far side of the host
`timescale 1ns/100ps
`default_nettype none
module asp_sram_model import asp_pkg::*; (
  input wire logic [ADDR_W-1:0] word_address_i, // word select
  input wire logic chip_sel_n_i, // chip select
  input wire logic write_en_n_i, // write enable
  input wire logic out_en_n_i, // output enable
  input wire logic low_byte_sel_n_i, // low lane select
  input wire logic high_byte_sel_n_i, // high lane select
  input wire logic [DATA_W-1:0] host_data_i, // host side of the bus
  input wire logic host_oe_i, // host drives the bus
  output logic [DATA_W-1:0] bus_o // resolved bus level
);
  logic [DATA_W-1:0] mem [WORD_COUNT]; // one entry per word
  logic [DATA_W-1:0] word;
  logic [1:0] win;
  logic [1:0] drv;
  logic [1:0] sel;
  assign sel = ~{high_byte_sel_n_i, low_byte_sel_n_i};
  assign win = {2{!chip_sel_n_i && !write_en_n_i}} & sel;
  assign drv = {2{!chip_sel_n_i && write_en_n_i && !out_en_n_i}} & sel;
  // capture at the end of the overlap; idle lanes untouched
  always @(negedge win[0]) mem[word_address_i][7:0] = host_data_i[7:0];
  always @(negedge win[1]) mem[word_address_i][15:8] = host_data_i[15:8];
  always @* begin
    word = mem[word_address_i];
    // released lanes show the inverse so an early sample is caught
    for (int i = 0; i < NUM_LANES; i++) begin
      bus_o[i*8+:8] = host_oe_i ? host_data_i[i*8+:8] : drv[i] ? word[i*8+:8] : ~word[i*8+:8];
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// random and corner bench for the sram host controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module tb_top import asp_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic wr = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [1:0] lane = 2'h0;
  logic ready, rvalid, cs_n, we_n, oe_n, lo_n, hi_n, tpin, hoe;
  logic [DATA_W-1:0] rdata, hbus, bus;
  logic [ADDR_W-1:0] maddr;
  logic [DATA_W-1:0] shadow [WORD_COUNT];
  logic [ADDR_W-1:0] pool [8];
  int num_errors = 0;
  int n_tests = 0;
  initial forever #10 clk = ~clk;
  asp_host dut (.ref_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(valid), .req_ready_o(ready),
    .req_write_i(wr), .req_addr_i(addr), .req_wdata_i(wdata), .req_lane_i(lane),
    .rsp_rdata_o(rdata), .rsp_valid_o(rvalid), .word_address_o(maddr), .chip_sel_n_o(cs_n),
    .write_en_n_o(we_n), .out_en_n_o(oe_n), .low_byte_sel_n_o(lo_n), .high_byte_sel_n_o(hi_n),
    .test_pin_tie_o(tpin), .data_lanes_i(bus), .data_lanes_o(hbus), .data_lanes_oe_o(hoe));
  asp_sram_model mem_u (.word_address_i(maddr), .chip_sel_n_i(cs_n), .write_en_n_i(we_n),
    .out_en_n_i(oe_n), .low_byte_sel_n_i(lo_n), .high_byte_sel_n_i(hi_n),
    .host_data_i(hbus), .host_oe_i(hoe), .bus_o(bus));
  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] l);
    return {{8{l[1]}}, {8{l[0]}}};
  endfunction
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [1:0] l);
    logic [DATA_W-1:0] m;
    int k;
    m = lane_mask(l);
    k = 0;
    @(negedge clk);
    while (ready !== 1'b1 && k < 10) begin
      @(negedge clk);
      k++;
    end
    `CHK(ready, 1'b1)
    valid = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    lane = l;
    @(negedge clk);
    valid = 1'b0;
    if (w) begin
      `CHK({cs_n, we_n, lo_n, hi_n, hoe}, {2'h0, ~l[0], ~l[1], 1'b1})
      shadow[a] = (shadow[a] & ~m) | (d & m);
    end else begin
      `CHK({cs_n, we_n, oe_n, lo_n, hi_n}, {3'h2, ~l[0], ~l[1]})
      k = 0;
      while (rvalid !== 1'b1 && k < 8) begin
        @(negedge clk);
        k++;
      end
      `CHK(rvalid, 1'b1)
      `CHK(rdata & m, shadow[a] & m)
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'h2e36_c5c3));
    repeat (2) @(negedge clk);
    `CHK({cs_n, we_n, oe_n, lo_n, hi_n, hoe}, 6'h3e)
    `CHK(tpin, 1'b0)
    rst_n = 1'b1;
    $display("test reset done");
    pool[0] = 18'h0_0000;
    pool[1] = 18'h3_ffff;
    for (int i = 2; i < 8; i++) pool[i] = ADDR_W'($urandom);
    foreach (pool[i]) access(1'b1, pool[i], DATA_W'($urandom), 2'h3);
    foreach (pool[i]) access(1'b0, pool[i], 16'h0000, 2'h3);
    $display("test corners done");
    // single lanes then whole word, back to back
    for (int l = 1; l < 4; l++) begin
      access(1'b1, pool[1], 16'ha5c3 ^ DATA_W'(l), 2'(l));
      access(1'b0, pool[1], 16'h0000, 2'h3);
    end
    $display("test lanes done");
    repeat (60) access(1'($urandom), pool[$urandom_range(7)], DATA_W'($urandom),
      2'($urandom_range(3, 1)));
    $display("test random done");
    close_out();
  end
endmodule
`default_nettype wire
